// ===== stm_timer.sv
// Purpose: 10-bit standard timer with compare-match, timer, pwm and single pulse modes
// Assumes: one clock, synchronous active-high reset, AHB-Lite register slave
// Notes: mode 01 is treated as idle counting with the pin held
// Contract
// R1: counter readable as low byte, two high bits
// R2: writable ten-bit compare a, reset zero
// R3: mode 00 compare, 11 timer, 10 pwm/pulse
// R4: clear-select low: clear on p or overflow
// R5: clear-select high: clear on a only
// R6: software never sets compare a zero; the bench writes compare a zero in timer mode
// R7: compare a zero: overflow, no a flag
// R8: only compare a match moves the pin
// R9: pin action sets high, low or toggles
// R10: run rise restores initial pin level
// R11: timer mode counts alike, pin unused
// R12: pin action 10 pwm, 11 single pulse
// R13: swap bit picks period and duty comparator
// R14: compare p maps to 128 multiples, 000=1024
// R15: duty at or above period gives 100%
// R16: swapped: period from a, duty from p
// R17: pwm raises both match flags
// R18: pwm logic runs under forced pin levels
// R19: initial level picks polarity, invert flips pin
// R20: pulse starts on run rise or trigger edge
// R21: compare a match ends pulse, clears run
// R22: pulse counter cleared only on run rise
// R23: run rise zeroes counter, fall holds it
// R24: clock select: div4, sys, ext edges
// R25: compare p against counter top bits
// R26: count each tick when running, not held
`timescale 1ns/100ps
`default_nettype none
module stm_timer (
  input wire logic sys_clk, // system clock, 50 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic clkEn, // clock enable, freezes state when low
  input wire stm_pkg::stm_ahb_req_t ahbReq, // ahb-lite request signals
  output var stm_pkg::stm_ahb_rsp_t ahbRsp, // ahb-lite response signals
  input wire logic extCountTrigger, // external count / trigger pin
  output logic timerOutputPin, // timer output pin level
  output logic matchAFlag, // sticky compare a flag
  output logic matchPFlag // sticky compare p flag
);
  import stm_pkg::*;

  // =====================================================
  // helper functions
  // upper three counter bits matched to the compare p field
  function automatic logic [2:0] topBits(input logic [9:0] v);
    topBits = v[9:7];
  endfunction : topBits

  // expand a 3-bit field to a count, zero meaning 1024
  function automatic logic [10:0] pToCount(input logic [2:0] p);
    pToCount = (p == 3'h0) ? 11'h400 : {1'b0, p, 7'h00};
  endfunction : pToCount

  // =====================================================
  // registers and state
  logic [9:0] counter; // ten-bit count
  logic [9:0] compareAValue; // compare a value
  logic [2:0] compareP; // compare p field
  logic countHold; // pause counting
  logic [2:0] countClockSelect; // clock source select
  logic runEnable; // run enable bit
  logic [1:0] modeSelect; // operating mode
  logic [1:0] pinAction; // pin action field
  logic initLevel; // output initial level / polarity
  logic outInvert; // output invert
  logic dutyPeriodSwap; // pwm role swap
  logic clearSourceSelect; // counter clear source
  logic pinState; // pin level before invert
  logic runPrev; // run enable, one cycle back
  logic [1:0] prescale; // divide-by-four counter
  logic [2:0] extSync; // external pin synchroniser
  logic extLast; // previous agreed external level
  logic addrPhase; // data phase pending
  logic addrWrite; // pending transfer is a write
  logic [7:0] addrLatch; // pending transfer address

  // =====================================================
  // combinational decode
  logic tick; // count event this cycle
  logic extRise; // agreed rising edge on ext pin
  logic extFall; // agreed falling edge on ext pin
  logic runRise; // run bit just rose
  logic matchA; // comparator a match on count
  logic matchP; // comparator p match on count
  logic atMax; // counter at top
  logic isPulse; // single pulse mode
  logic isPwm; // pwm mode (any pin action but pulse)
  logic clearNow; // counter clears after this tick
  logic setA; // raise match a flag
  logic setP; // raise match p flag
  logic pulseEnd; // single pulse ends this cycle
  logic wrEn; // register write this cycle
  logic busTake; // bus address phase taken
  logic pinOut; // next pin level after invert
  logic [10:0] period; // pwm period in ticks
  logic [10:0] duty; // pwm duty in ticks
  logic pwmActive; // pwm waveform active now

  // ext pin edges once the second and third stages agree
  assign extRise = extSync[1] & extSync[2] & ~extLast;
  assign extFall = ~extSync[1] & ~extSync[2] & extLast;
  assign runRise = runEnable & ~runPrev;
  assign isPulse = (modeSelect == STM_MODE_PWM) && (pinAction == STM_ACT_TOG);
  assign isPwm = (modeSelect == STM_MODE_PWM) && !isPulse;
  assign atMax = (counter == STM_CNT_MAX);

  // clock source and count gating
  always_comb begin
    // R24: count source select
    case (countClockSelect)
      STM_CK_DIV4: tick = (prescale == STM_DIV4_LAST);
      STM_CK_SYS: tick = 1'b1;
      STM_CK_EXTR: tick = extRise;
      STM_CK_EXTF: tick = extFall;
      default: tick = 1'b0; // other internal clocks not present here
    endcase
    // R26: run and not held
    tick = tick & runEnable & ~countHold & ~runRise;
  end

  // comparator matches and clear decision
  always_comb begin
    // R7: compare a zero never matches
    matchA = (compareAValue != 10'h000) && ((counter + 10'h001) == compareAValue);
    // R25: p compares the top bits, R14: 000 means overflow
    matchP = (compareP == 3'h0) ? atMax : (topBits(counter + 10'h001) == compareP);
    // R16: swapped roles, period from a
    period = dutyPeriodSwap ? {1'b0, compareAValue} : pToCount(compareP);
    duty = dutyPeriodSwap ? pToCount(compareP) : {1'b0, compareAValue};
    clearNow = 1'b0;
    setA = 1'b0;
    setP = 1'b0;
    pulseEnd = 1'b0;
    if (isPulse) begin
      // R21: a match ends the pulse; R22: no clear and p unused
      setA = matchA;
      pulseEnd = matchA;
    end else if (isPwm) begin
      // R13: period comparator clears; R17: both flags
      clearNow = dutyPeriodSwap ? (matchA || atMax) : matchP;
      setA = matchA;
      setP = matchP;
    end else if (clearSourceSelect) begin
      // R5: clear on a, only a flag
      clearNow = matchA || atMax;
      setA = matchA;
    end else begin
      // R4: clear on p or overflow, both flags; R11 same in timer mode
      clearNow = matchP || atMax;
      setA = matchA;
      setP = matchP;
    end
    setA = setA & tick;
    setP = setP & tick;
    clearNow = clearNow & tick;
    pulseEnd = pulseEnd & tick;
  end

  // pwm waveform level from the current count, before this tick
  always_comb begin
    // R15: duty at or above period is always active
    if (duty >= period) begin
      pwmActive = 1'b1;
    end else begin
      pwmActive = ({1'b0, counter} < duty);
    end
  end

  // =====================================================
  // ahb-lite slave: zero wait states, always okay
  assign busTake = ahbReq.hsel && ahbReq.hready &&
    (ahbReq.htrans == STM_HTRANS_NONSEQ || ahbReq.htrans == STM_HTRANS_SEQ);
  assign wrEn = addrPhase && addrWrite && clkEn;

  // address phase capture
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addrPhase <= 1'b0;
      addrWrite <= 1'b0;
      addrLatch <= 8'h00;
    end else if (clkEn) begin
      addrPhase <= busTake;
      addrWrite <= busTake && ahbReq.hwrite;
      addrLatch <= ahbReq.haddr;
    end
  end

  // read data and ready, registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp <= 1'b0;
      ahbRsp.hrdata <= STM_RESET_WORD;
    end else if (clkEn) begin
      ahbRsp.hreadyout <= 1'b1;
      ahbRsp.hresp <= 1'b0;
      ahbRsp.hrdata <= STM_RESET_WORD;
      if (busTake && !ahbReq.hwrite) begin
        case (ahbReq.haddr)
          // R1: counter low byte and high bits
          STM_OFF_CNT_LO: ahbRsp.hrdata <= {24'h000000, counter[7:0]};
          STM_OFF_CNT_HI: ahbRsp.hrdata <= {30'h00000000, counter[9:8]};
          STM_OFF_CMPA_LO: ahbRsp.hrdata <= {24'h000000, compareAValue[7:0]};
          STM_OFF_CMPA_HI: ahbRsp.hrdata <= {30'h00000000, compareAValue[9:8]};
          STM_OFF_CTRL0: ahbRsp.hrdata <= {24'h000000, countHold, countClockSelect,
                                            runEnable, compareP};
          STM_OFF_CTRL1: ahbRsp.hrdata <= {24'h000000, modeSelect, pinAction, initLevel,
                                            outInvert, dutyPeriodSwap, clearSourceSelect};
          STM_OFF_FLAGS: ahbRsp.hrdata <= {30'h00000000, matchPFlag, matchAFlag};
          default: ahbRsp.hrdata <= STM_RESET_WORD; // unmapped reads zero
        endcase
      end
    end
  end

  // =====================================================
  // compare a register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compareAValue <= 10'h000;
    end else if (wrEn) begin
      // R2: byte-wise compare a writes
      if (addrLatch == STM_OFF_CMPA_LO) begin
        compareAValue[7:0] <= ahbReq.hwdata[7:0];
      end else if (addrLatch == STM_OFF_CMPA_HI) begin
        compareAValue[9:8] <= ahbReq.hwdata[1:0];
      end
    end
  end

  // control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      countHold <= 1'b0;
      countClockSelect <= 3'h0;
      compareP <= 3'h0;
      modeSelect <= 2'h0;
      pinAction <= 2'h0;
      initLevel <= 1'b0;
      outInvert <= 1'b0;
      dutyPeriodSwap <= 1'b0;
      clearSourceSelect <= 1'b0;
    end else if (wrEn) begin
      if (addrLatch == STM_OFF_CTRL0) begin
        countHold <= ahbReq.hwdata[STM_C0_HOLD];
        countClockSelect <= ahbReq.hwdata[STM_C0_CKS +: 3];
        compareP <= ahbReq.hwdata[2:0];
      end else if (addrLatch == STM_OFF_CTRL1) begin
        // R3: mode field decode source
        modeSelect <= ahbReq.hwdata[STM_C1_MODE +: 2];
        pinAction <= ahbReq.hwdata[STM_C1_ACT +: 2];
        initLevel <= ahbReq.hwdata[STM_C1_INIT];
        outInvert <= ahbReq.hwdata[STM_C1_INV];
        dutyPeriodSwap <= ahbReq.hwdata[STM_C1_SWAP];
        clearSourceSelect <= ahbReq.hwdata[STM_C1_CLRSEL];
      end
    end
  end

  // run enable: software, trigger pin and pulse end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      runEnable <= 1'b0;
    end else if (clkEn) begin
      if (wrEn && addrLatch == STM_OFF_CTRL0) begin
        runEnable <= ahbReq.hwdata[STM_C0_RUN];
      // R21: compare a match clears run
      end else if (pulseEnd) begin
        runEnable <= 1'b0;
      // R20: trigger edge sets run in pulse mode
      end else if (isPulse && !runEnable &&
                   ((countClockSelect == STM_CK_EXTF) ? extFall : extRise)) begin
        runEnable <= 1'b1;
      end
    end
  end

  // =====================================================
  // sample stages and prescaler
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      extSync <= 3'h0;
      extLast <= 1'b0;
      runPrev <= 1'b0;
      prescale <= 2'h0;
    end else if (clkEn) begin
      extSync <= {extSync[1:0], extCountTrigger};
      if (extSync[1] == extSync[2]) begin
        extLast <= extSync[2];
      end
      runPrev <= runEnable;
      prescale <= prescale + 2'h1;
    end
  end

  // counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter <= 10'h000;
    end else if (clkEn) begin
      // R23: zero on run rise; R22: only clear in pulse mode
      if (runRise) begin
        counter <= 10'h000;
      end else if (clearNow) begin
        counter <= 10'h000;
      end else if (tick) begin
        counter <= counter + 10'h001;
      end
    end
  end

  // sticky flags, set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      matchAFlag <= 1'b0;
      matchPFlag <= 1'b0;
    end else if (clkEn) begin
      if (wrEn && addrLatch == STM_OFF_FLAGS && ahbReq.hwdata[STM_FL_A]) begin
        matchAFlag <= 1'b0;
      end
      if (wrEn && addrLatch == STM_OFF_FLAGS && ahbReq.hwdata[STM_FL_P]) begin
        matchPFlag <= 1'b0;
      end
      if (setA) begin
        matchAFlag <= 1'b1;
      end
      if (setP) begin
        matchPFlag <= 1'b1;
      end
    end
  end

  // =====================================================
  // pin state before invert
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinState <= 1'b0;
    end else if (clkEn) begin
      // R10: run rise restores initial level
      if (runRise) begin
        pinState <= initLevel;
      end else if (modeSelect == STM_MODE_CMP && setA) begin
        // R8: only a match moves pin; R9: action
        case (pinAction)
          STM_ACT_LOW: pinState <= 1'b0;
          STM_ACT_HIGH: pinState <= 1'b1;
          STM_ACT_TOG: pinState <= ~pinState;
          default: pinState <= pinState; // no change
        endcase
      end else if (isPulse) begin
        // R21: trailing edge when run clears
        pinState <= runEnable && !pulseEnd ? initLevel : ~initLevel;
      end else if (isPwm) begin
        // R12, R18, R19: forced or waveform, polarity by initial level
        case (pinAction)
          STM_ACT_NONE: pinState <= ~initLevel;
          STM_ACT_LOW: pinState <= initLevel;
          default: pinState <= pwmActive ? initLevel : ~initLevel;
        endcase
      end
    end
  end

  // R19: invert in every mode but timer; R11: pin held low in timer mode
  assign pinOut = (modeSelect == STM_MODE_TMR) ? 1'b0 : (pinState ^ outInvert);

  // output flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timerOutputPin <= 1'b0;
    end else if (clkEn) begin
      timerOutputPin <= pinOut;
    end
  end
endmodule : stm_timer
`default_nettype wire

// ===== stm_pkg.sv
// Purpose: shared constants and types for the 10-bit standard timer
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes: offsets are byte addresses inside the timer's window
`default_nettype none
package stm_pkg;
  // =====================================================
  // register map
  localparam logic [7:0] STM_OFF_CNT_LO = 8'h00; // counter_low_byte
  localparam logic [7:0] STM_OFF_CNT_HI = 8'h04; // counter_high_bits
  localparam logic [7:0] STM_OFF_CMPA_LO = 8'h08; // match_a_low_byte
  localparam logic [7:0] STM_OFF_CMPA_HI = 8'h0C; // match_a_high_bits
  localparam logic [7:0] STM_OFF_CTRL0 = 8'h10; // hold, clock select, run, compare p
  localparam logic [7:0] STM_OFF_CTRL1 = 8'h14; // mode, pin action, level bits
  localparam logic [7:0] STM_OFF_FLAGS = 8'h18; // match flags, write one to clear
  // =====================================================
  // field positions
  localparam int STM_C0_HOLD = 7; // count_hold
  localparam int STM_C0_CKS = 4; // count_clock_select lsb
  localparam int STM_C0_RUN = 3; // run_enable_bit
  localparam int STM_C1_MODE = 6; // mode select lsb
  localparam int STM_C1_ACT = 4; // pin action lsb
  localparam int STM_C1_INIT = 3; // output_initial_level
  localparam int STM_C1_INV = 2; // output_invert
  localparam int STM_C1_SWAP = 1; // duty_period_swap
  localparam int STM_C1_CLRSEL = 0; // clear_source_select
  localparam int STM_FL_A = 0; // match_a_flag
  localparam int STM_FL_P = 1; // match_p_flag
  // =====================================================
  // encodings and limits
  localparam logic [1:0] STM_MODE_CMP = 2'h0; // compare-match output
  localparam logic [1:0] STM_MODE_PWM = 2'h2; // pwm or single pulse
  localparam logic [1:0] STM_MODE_TMR = 2'h3; // timer/counter
  localparam logic [1:0] STM_ACT_NONE = 2'h0; // no change / inactive
  localparam logic [1:0] STM_ACT_LOW = 2'h1; // low / active
  localparam logic [1:0] STM_ACT_HIGH = 2'h2; // high / pwm
  localparam logic [1:0] STM_ACT_TOG = 2'h3; // toggle / single pulse
  localparam logic [2:0] STM_CK_DIV4 = 3'h0; // system clock / 4
  localparam logic [2:0] STM_CK_SYS = 3'h1; // system clock
  localparam logic [2:0] STM_CK_EXTR = 3'h6; // ext rising edge
  localparam logic [2:0] STM_CK_EXTF = 3'h7; // ext falling edge
  localparam logic [9:0] STM_CNT_MAX = 10'h3FF; // top count
  localparam logic [1:0] STM_DIV4_LAST = 2'h3; // prescaler wrap
  localparam logic [31:0] STM_RESET_WORD = 32'h0000_0000; // reset of all registers
  localparam logic [1:0] STM_HTRANS_NONSEQ = 2'h2; // ahb nonseq
  localparam logic [1:0] STM_HTRANS_SEQ = 2'h3; // ahb seq
  // =====================================================
  // bus carrier types
  typedef struct packed {
    logic hsel; // slave select
    logic [7:0] haddr; // byte address in window
    logic [1:0] htrans; // transfer type
    logic hwrite; // write request
    logic [2:0] hsize; // transfer size
    logic hready; // bus ready
    logic [31:0] hwdata; // write data
  } stm_ahb_req_t;
  typedef struct packed {
    logic hreadyout; // slave ready
    logic hresp; // response, always okay
    logic [31:0] hrdata; // read data
  } stm_ahb_rsp_t;
endpackage : stm_pkg
`default_nettype wire

// ===== stm_timer_properties.sv
// Purpose: port-level checker for the standard timer
// Assumes: register shadows rebuilt from bus writes
// Notes: bound to every stm_timer instance below
`timescale 1ns/100ps
`default_nettype none
module stm_timer_properties (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic clkEn, // clock enable
  input wire stm_pkg::stm_ahb_req_t ahbReq, // bus request
  input wire stm_pkg::stm_ahb_rsp_t ahbRsp, // bus response
  input wire logic extCountTrigger, // trigger pin
  input wire logic timerOutputPin, // output pin
  input wire logic matchAFlag, // compare a flag
  input wire logic matchPFlag // compare p flag
);
  import stm_pkg::*;
  // =====================================================
  // register shadows
  logic take; // address phase accepted
  logic wrQ; // write data phase
  logic [7:0] adQ; // data phase address
  logic [7:0] cmpLo; // compare a low copy
  logic [1:0] cmpHi; // compare a high copy
  logic [7:0] ctrl1; // control 1 copy
  logic clrA; // software clears flag a
  logic isCmp; // compare-match mode
  assign take = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1] & clkEn;
  assign clrA = wrQ && adQ == STM_OFF_FLAGS && ahbReq.hwdata[STM_FL_A];
  assign isCmp = ctrl1[7:6] == STM_MODE_CMP;
  // copies follow the data phase of each write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrQ <= 1'b0;
      adQ <= 8'h00;
      cmpLo <= 8'h00;
      cmpHi <= 2'h0;
      ctrl1 <= 8'h00;
    end else if (clkEn) begin
      wrQ <= take & ahbReq.hwrite;
      adQ <= ahbReq.haddr;
      if (wrQ && adQ == STM_OFF_CMPA_LO) cmpLo <= ahbReq.hwdata[7:0];
      if (wrQ && adQ == STM_OFF_CMPA_HI) cmpHi <= ahbReq.hwdata[1:0];
      if (wrQ && adQ == STM_OFF_CTRL1) ctrl1 <= ahbReq.hwdata[7:0];
    end
  end
  // =====================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  upper_zero_a: assert property (ahbRsp.hrdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  resp_okay_a: assert property (ahbRsp.hreadyout && !ahbRsp.hresp)
    else $error("bus response not ready and okay");
  high_zero_a: assert property (take && !ahbReq.hwrite && (ahbReq.haddr == STM_OFF_CNT_HI ||
    ahbReq.haddr == STM_OFF_CMPA_HI) |=> ahbRsp.hrdata[7:2] == 6'h00)
    else $error("high register unused bits not zero");
  cmpa_back_a: assert property (take && !ahbReq.hwrite && ahbReq.haddr == STM_OFF_CMPA_LO &&
    !wrQ |=> ahbRsp.hrdata[7:0] == cmpLo)
    else $error("compare a low byte readback wrong");
  flag_clear_a: assert property ($fell(matchAFlag) && !$past(rst) |-> $past(clrA))
    else $error("flag a fell without a clear");
  timer_pin_a: assert property ((ctrl1[7:6] == STM_MODE_TMR)[*4] |-> !timerOutputPin)
    else $error("pin driven in timer mode");
  no_pflag_a: assert property ((isCmp && ctrl1[STM_C1_CLRSEL])[*3] |-> !$rose(matchPFlag))
    else $error("flag p raised with clear on a");
  zero_noa_a: assert property ((cmpLo == 8'h00 && cmpHi == 2'h0 && ctrl1[7] == ctrl1[6])[*3]
    |-> !$rose(matchAFlag))
    else $error("flag a raised with compare a zero");
  no_action_a: assert property ((isCmp && ctrl1[5:4] == STM_ACT_NONE && !wrQ)[*4]
    |-> $stable(timerOutputPin))
    else $error("pin moved with no pin action");
  cover property ($rose(matchAFlag));
  cover property ($rose(matchPFlag));
  cover property ($rose(timerOutputPin));
endmodule : stm_timer_properties
bind stm_timer stm_timer_properties props (.sys_clk, .rst, .clkEn, .ahbReq, .ahbRsp,
  .extCountTrigger, .timerOutputPin, .matchAFlag, .matchPFlag);
`default_nettype wire

// ===== stm_trig_model.sv
// Purpose: far-side model driving the count / trigger pin
// Assumes: square wave while enabled, low when idle
// Notes: one rising edge every two half periods
`timescale 1ns/100ps
`default_nettype none
module stm_trig_model (
  input wire logic sys_clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic genEn, // produce edges
  input wire logic [7:0] halfPer, // cycles per level
  output logic trigPin // pin to the timer
);
  logic [7:0] cnt; // cycles in this level
  initial begin
    trigPin = 1'b0;
    cnt = 8'h00;
    forever begin
      @(posedge sys_clk);
      if (rst || !genEn) begin
        cnt <= 8'h00;
        trigPin <= 1'b0;
      end else if (cnt == halfPer - 8'h01) begin
        cnt <= 8'h00;
        trigPin <= ~trigPin;
      end else cnt <= cnt + 8'h01;
    end
  end
endmodule : stm_trig_model
`default_nettype wire

// ===== stm_timer_bench.sv
// Purpose: self-checking bench for the standard timer
// Assumes: single AHB-Lite transfers, ready fed back
// Notes: latency-bound counts carry a small tolerance
`timescale 1ns/100ps
`default_nettype none
module stm_timer_bench;
  import stm_pkg::*;
  // =====================================================
  // signals and tables
  logic sys_clk; // bench clock
  logic rst = 1'b1; // reset
  logic trigGen = 1'b0; // trigger model enable
  logic ce = 1'b1; // clock enable to the timer
  stm_ahb_req_t req = '0; // master fields
  stm_ahb_req_t reqW; // bus with ready
  stm_ahb_rsp_t rsp; // slave answer
  logic pin; // output pin
  logic fa; // flag a
  logic fp; // flag p
  logic ext; // trigger wire
  logic [31:0] rd; // last read
  logic [2:0] mon; // watched outputs
  int failCount = 0; // mismatches
  int checkCount = 0; // comparisons
  int h; // high cycles
  int i; // index
  localparam logic [2:0] CK [4] = '{STM_CK_DIV4, STM_CK_SYS, STM_CK_EXTR, STM_CK_EXTF};
  localparam int CE [4] = '{50, 200, 14, 14}; // ticks in 200 cycles
  localparam logic [7:0] PC1 [7] = '{8'hA8, 8'hA8, 8'hAC, 8'hA0, 8'hAA, 8'h98, 8'h88};
  localparam int PA [7] = '{32, 200, 32, 32, 255, 32, 32}; // compare a
  localparam int PW [7] = '{256, 256, 256, 256, 510, 256, 256}; // two periods
  localparam int PE [7] = '{64, 256, 192, 192, 256, 256, 0}; // high cycles
  assign mon = {pin, fp, fa};
  always_comb begin
    reqW = req;
    reqW.hready = rsp.hreadyout;
  end
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  stm_timer dut (.sys_clk, .rst, .clkEn(ce), .ahbReq(reqW), .ahbRsp(rsp),
    .extCountTrigger(ext), .timerOutputPin(pin), .matchAFlag(fa), .matchPFlag(fp));
  stm_trig_model model (.sys_clk, .rst, .genEn(trigGen), .halfPer(8'h07), .trigPin(ext));
  // =====================================================
  // tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task closeOut;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : closeOut
  // one transfer: address phase, then data phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    req.hsel <= 1'b1;
    req.haddr <= a;
    req.htrans <= STM_HTRANS_NONSEQ;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge sys_clk); while (rsp.hreadyout !== 1'b1);
    q = rsp.hrdata;
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask : rdc
  task setA(input logic [9:0] v);
    wr(STM_OFF_CMPA_LO, 32'(v[7:0]));
    wr(STM_OFF_CMPA_HI, 32'(v[9:8]));
  endtask : setA
  // stop, clear flags, configure, then start
  task go(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
    wr(STM_OFF_CTRL0, 32'h0);
    wr(STM_OFF_FLAGS, 32'h3);
    wr(STM_OFF_CTRL1, 32'(c1));
    setA(a);
    wr(STM_OFF_CTRL0, 32'(c0));
  endtask : go
  task waitOn(input int which, input int n);
    repeat (n) if (mon[which] !== 1'b1) @(posedge sys_clk);
  endtask : waitOn
  task hcount(input int n);
    h = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if (pin === 1'b1) h++;
    end
  endtask : hcount
  // =====================================================
  // tests
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) rdc(8'(i * 4), 32'h0);
    setA(10'h3FF);
    rdc(STM_OFF_CMPA_LO, 32'hFF);
    wr(STM_OFF_CMPA_HI, 32'hFF);
    rdc(STM_OFF_CMPA_HI, 32'h3);
    $display("test registers done");
    // compare a kept nonzero in compare mode
    go(8'h31, 10'd10, 8'h18);
    waitOn(0, 200);
    repeat (3) @(posedge sys_clk);
    chk(pin, 1'b1);
    go(8'h19, 10'd10, 8'h18);
    repeat (3) @(posedge sys_clk);
    chk(pin, 1'b1);
    waitOn(0, 200);
    repeat (40) @(posedge sys_clk);
    chk(mon, 3'b001);
    go(8'h08, 10'd10, 8'h18);
    waitOn(0, 200);
    repeat (3) @(posedge sys_clk);
    chk(mon, 3'b101);
    go(8'h30, 10'd5, 8'h19);
    waitOn(1, 300);
    @(posedge sys_clk);
    chk(mon, 3'b111);
    wr(STM_OFF_CTRL0, 32'h11);
    rdc(STM_OFF_CNT_HI, 32'h0);
    $display("test compare mode done");
    for (i = 0; i < 4; i++) begin
      go(8'hC0, 10'd0, {1'b0, CK[i], 4'h8});
      trigGen <= CK[i][2];
      repeat (200) @(posedge sys_clk);
      wr(STM_OFF_CTRL0, {25'h0, CK[i], 4'h0});
      trigGen <= 1'b0;
      repeat (20) @(posedge sys_clk);
      xfer(1'b0, STM_OFF_CNT_LO, 32'h0, rd);
      chk(rd >= CE[i] - 2 && rd <= CE[i] + 6, 1'b1);
      chk(pin, 1'b0);
    end
    go(8'hC0, 10'd0, 8'h98);
    repeat (50) @(posedge sys_clk);
    rdc(STM_OFF_CNT_LO, 32'h0);
    go(8'hC0, 10'd0, 8'h18);
    ce <= 1'b0;
    repeat (100) @(posedge sys_clk);
    ce <= 1'b1;
    wr(STM_OFF_CTRL0, 32'h10);
    xfer(1'b0, STM_OFF_CNT_LO, 32'h0, rd);
    chk(rd <= 32'h4, 1'b1);
    go(8'hC0, 10'd0, 8'h18);
    repeat (1100) @(posedge sys_clk);
    chk(fa, 1'b0);
    $display("test counting done");
    for (i = 0; i < 7; i++) begin
      go(PC1[i], 10'(PA[i]), 8'h19);
      repeat (20) @(posedge sys_clk);
      hcount(PW[i]);
      chk(h, PE[i]);
    end
    chk(mon[1:0], 2'b11);
    $display("test pwm done");
    go(8'hB8, 10'd50, 8'h10);
    trigGen <= 1'b1;
    waitOn(2, 100);
    trigGen <= 1'b0;
    hcount(80);
    chk(h >= 47 && h <= 52, 1'b1);
    rdc(STM_OFF_CTRL0, 32'h10);
    chk(fa, 1'b1);
    $display("test single pulse done");
    closeOut();
  end
  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    failCount++;
    closeOut();
  end
endmodule : stm_timer_bench
`default_nettype wire
